// [rtl/cca_array.sv]
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (RULE_01) Counter wrap from FFFF to 0000 sets overflow flag; only software clears it.
// (RULE_02) Set overflow flag with its enable raises the array interrupt.
// (RULE_03) Control bit 6 runs the counter when 1, stops it when 0.
// (RULE_04) Match or capture sets a module flag; only software write clears it.
// (RULE_05) Set module flag with its enable raises the shared array interrupt.
// (RULE_06) Control: bit 7 overflow, bit 6 run, bits 5..0 module flags, all read/write.
// (RULE_07) Each module keeps a 16-bit value at separate low and high byte addresses.
// (RULE_08) Reload select steers byte accesses to the module's PWM reload value.
// (RULE_09) Writing a module low byte clears its compare enable.
// (RULE_10) Writing a module high byte sets its compare enable.
// (RULE_11) Enabled module matches when counter equals its 16-bit value.
// (RULE_12) Software writes low byte before high byte.
module cca_array (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic reload_select,
  input wire logic ovf_int_en,
  input wire logic [5:0] match_int_en,
  input wire logic [5:0] capture_event,
  output logic [7:0] sfr_rdata,
  output logic sfr_rd_hit,
  output logic irq,
  output logic [15:0] count_value,
  output logic [5:0] compare_enable,
  output logic [5:0] match_pulse
);
  localparam int N = cca_pkg::NUM_CH;

  cca_pkg::cca_top_state_t state_reg;
  cca_pkg::cca_top_state_t state_next;

  logic [15:0] cnt_count;
  logic cnt_step;
  logic cnt_wrap;
  logic ctrl_wr;
  wire logic [N-1:0] wr_low;
  wire logic [N-1:0] wr_high;
  wire logic [N-1:0] ch_match;
  wire logic [N-1:0] ch_cmp_en;
  logic [15:0] ch_value [N];
  logic [15:0] ch_reload [N];
  logic [N-1:0] flag_set;

  cca_counter u_counter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(state_reg.run),
    .count(cnt_count),
    .step(cnt_step),
    .wrap(cnt_wrap)
  );

  assign ctrl_wr = sfr_wr && (sfr_addr == cca_pkg::CTRL_ADDR);

  cca_chan_if ch_if [N] ();

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      // RULE_07 byte address decode
      assign wr_low[gi] = sfr_wr && (sfr_addr == cca_pkg::LOW_ADDR[gi]);
      assign wr_high[gi] = sfr_wr && (sfr_addr == cca_pkg::HIGH_ADDR[gi]);
      assign ch_if[gi].wr_low = wr_low[gi];
      assign ch_if[gi].wr_high = wr_high[gi];
      assign ch_if[gi].reload_sel = reload_select;
      assign ch_if[gi].wdata = sfr_wdata;
      assign ch_if[gi].count = cnt_count;
      assign ch_if[gi].step = cnt_step;
      assign ch_value[gi] = ch_if[gi].value;
      assign ch_reload[gi] = ch_if[gi].reload;
      assign ch_cmp_en[gi] = ch_if[gi].cmp_en;
      assign ch_match[gi] = ch_if[gi].match;
      cca_channel u_channel (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bus(ch_if[gi])
      );
    end
  endgenerate

  // RULE_04 match or capture event
  assign flag_set = ch_match | capture_event;

  always_comb begin
    state_next = state_reg;
    // RULE_06 control register write
    if (ctrl_wr) begin
      state_next.ovf_flag = sfr_wdata[cca_pkg::CTRL_OVF_BIT];
      // RULE_03 software run control
      state_next.run = sfr_wdata[cca_pkg::CTRL_RUN_BIT];
      state_next.mod_flag = sfr_wdata[N-1:0];
    end
    // RULE_01 set beats clear
    if (cnt_wrap) begin
      state_next.ovf_flag = 1'b1;
    end
    // RULE_04 set beats clear
    state_next.mod_flag = state_next.mod_flag | flag_set;
    // Read data is held until the next read so the core can sample late
    if (sfr_rd) begin
      state_next.rdata = cca_pkg::READ_IDLE;
      state_next.rd_hit = 1'b0;
      if (sfr_addr == cca_pkg::CTRL_ADDR) begin
        state_next.rdata = {state_reg.ovf_flag, state_reg.run, state_reg.mod_flag};
        state_next.rd_hit = 1'b1;
      end
      for (int i = 0; i < N; i++) begin
        // RULE_08 reload read routing
        if (sfr_addr == cca_pkg::LOW_ADDR[i]) begin
          state_next.rdata = reload_select ? ch_reload[i][7:0] : ch_value[i][7:0];
          state_next.rd_hit = 1'b1;
        end
        if (sfr_addr == cca_pkg::HIGH_ADDR[i]) begin
          state_next.rdata = reload_select ? ch_reload[i][15:8] : ch_value[i][15:8];
          state_next.rd_hit = 1'b1;
        end
      end
    end else begin
      state_next.rd_hit = 1'b0;
    end
    // RULE_02 overflow interrupt
    // RULE_05 module flag interrupt
    state_next.irq = (state_reg.ovf_flag && ovf_int_en) || (|(state_reg.mod_flag & match_int_en));
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cca_pkg::TOP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = state_reg.rdata;
  assign sfr_rd_hit = state_reg.rd_hit;
  assign irq = state_reg.irq;
  assign count_value = cnt_count;
  assign compare_enable = ch_cmp_en;
  assign match_pulse = ch_match;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // RULE_01 wrap sets flag
  chk_ovf_set: assert property (cnt_wrap |=> state_reg.ovf_flag) // RULE_01
    else $error("wrap did not set overflow flag");

  // RULE_01 flag stays set
  chk_ovf_sticky: assert property (state_reg.ovf_flag && !ctrl_wr |=> state_reg.ovf_flag) // RULE_01
    else $error("overflow flag dropped without software");

  // RULE_01 only wrap or control write sets
  chk_ovf_source: assert property ( // RULE_01
    !state_reg.ovf_flag && !ctrl_wr && !cnt_wrap |=> !state_reg.ovf_flag)
    else $error("overflow flag set without wrap");

  // RULE_02 overflow raises interrupt
  chk_irq_ovf: assert property (state_reg.ovf_flag && ovf_int_en |=> irq) // RULE_02
    else $error("overflow interrupt missing");

  // RULE_03 run bit written
  chk_run_bit: assert property (ctrl_wr |=> state_reg.run == $past(sfr_wdata[6])) // RULE_03
    else $error("run bit not taken from write");

  // RULE_03 running counter steps
  chk_run_count: assert property ( // RULE_03
    state_reg.run |=> cnt_step && (cnt_count == $past(cnt_count) + cca_pkg::COUNT_STEP))
    else $error("counter did not step while running");

  // RULE_04 event sets flag
  chk_flag_set: assert property (|flag_set |=> ((state_reg.mod_flag & $past(flag_set)) == $past(flag_set))) // RULE_04
    else $error("module flag not set by event");

  // RULE_04 flags stay set
  chk_flag_sticky: assert property (!ctrl_wr |=> ((~state_reg.mod_flag & $past(state_reg.mod_flag)) == 6'h00)) // RULE_04
    else $error("module flag cleared by hardware");

  // RULE_05 module flag interrupt
  chk_irq_match: assert property (|(state_reg.mod_flag & match_int_en) |=> irq) // RULE_05
    else $error("module interrupt missing");

  // RULE_05 interrupt needs cause
  chk_irq_cause: assert property (irq |-> $past(state_reg.ovf_flag && ovf_int_en) // RULE_05
    || $past(|(state_reg.mod_flag & match_int_en)))
    else $error("interrupt without cause");

  // RULE_06 control read data
  chk_ctrl_read: assert property (sfr_rd && sfr_addr == cca_pkg::CTRL_ADDR && !ctrl_wr // RULE_06
    |=> sfr_rdata == {$past(state_reg.ovf_flag), $past(state_reg.run), $past(state_reg.mod_flag)})
    else $error("control read data wrong");

  // RULE_06 control write stored
  chk_ctrl_write: assert property ( // RULE_06
    ctrl_wr && !cnt_wrap && !(|flag_set) |=> (state_reg.ovf_flag == $past(sfr_wdata[cca_pkg::CTRL_OVF_BIT]))
    && (state_reg.mod_flag == $past(sfr_wdata[N-1:0])))
    else $error("control write not stored");

  // RULE_06 hit needs read
  chk_rd_hit_idle: assert property (!sfr_rd |=> !sfr_rd_hit) // RULE_06
    else $error("read hit without read strobe");

  // RULE_06 read data held
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata)) // RULE_06
    else $error("read data changed without read");

  // RULE_07 low byte read
  chk_low_read: assert property (sfr_rd && sfr_addr == cca_pkg::LOW_ADDR[0] && !reload_select // RULE_07
    |=> sfr_rdata == $past(ch_value[0][7:0]))
    else $error("module value read wrong");

  generate
    for (gi = 0; gi < N; gi++) begin : g_chk
      // RULE_07 low byte stored
      chk_low_store: assert property ( // RULE_07
        wr_low[gi] && !reload_select |=> ch_value[gi][7:0] == $past(sfr_wdata))
        else $error("low byte not stored");

      // RULE_07 high byte stored
      chk_high_store: assert property ( // RULE_07
        wr_high[gi] && !reload_select |=> ch_value[gi][15:8] == $past(sfr_wdata))
        else $error("high byte not stored");

      // RULE_07 value held
      chk_value_hold: assert property ( // RULE_07
        !wr_low[gi] && !wr_high[gi] |=> $stable(ch_value[gi]) && $stable(ch_reload[gi]))
        else $error("module value changed without write");

      // RULE_07 every low read
      chk_low_read_all: assert property ( // RULE_07
        sfr_rd && !sfr_wr && sfr_addr == cca_pkg::LOW_ADDR[gi] && !reload_select
        |=> sfr_rd_hit && sfr_rdata == $past(ch_value[gi][7:0]))
        else $error("low byte read wrong");

      // RULE_07 every high read
      chk_high_read: assert property ( // RULE_07
        sfr_rd && !sfr_wr && sfr_addr == cca_pkg::HIGH_ADDR[gi] && !reload_select
        |=> sfr_rd_hit && sfr_rdata == $past(ch_value[gi][15:8]))
        else $error("high byte read wrong");

      // RULE_08 reload low write
      chk_reload_low: assert property ( // RULE_08
        wr_low[gi] && reload_select |=> ch_reload[gi][7:0] == $past(sfr_wdata) && $stable(ch_value[gi]))
        else $error("reload low byte misrouted");

      // RULE_08 reload high write
      chk_reload_high: assert property ( // RULE_08
        wr_high[gi] && reload_select |=> ch_reload[gi][15:8] == $past(sfr_wdata) && $stable(ch_value[gi]))
        else $error("reload high byte misrouted");

      // RULE_08 reload read
      chk_reload_read: assert property ( // RULE_08
        sfr_rd && !sfr_wr && sfr_addr == cca_pkg::LOW_ADDR[gi] && reload_select
        |=> sfr_rd_hit && sfr_rdata == $past(ch_reload[gi][7:0]))
        else $error("reload read wrong");

      // RULE_09 low write disables
      chk_low_write: assert property ( // RULE_09
        wr_low[gi] && !wr_high[gi] |=> !ch_cmp_en[gi])
        else $error("low write left compare enabled");

      // RULE_10 high write enables
      chk_high_write: assert property ( // RULE_10
        wr_high[gi] |=> ch_cmp_en[gi])
        else $error("high write left compare disabled");

      // RULE_04 match sets flag
      chk_match_flag: assert property ( // RULE_04
        ch_match[gi] |=> state_reg.mod_flag[gi])
        else $error("match did not set module flag");

      // RULE_04 capture sets flag
      chk_capture_flag: assert property ( // RULE_04
        capture_event[gi] |=> state_reg.mod_flag[gi])
        else $error("capture did not set module flag");

      // RULE_11 match needs step
      chk_match_step: assert property ( // RULE_11
        !cnt_step |=> !ch_match[gi])
        else $error("match while counter stopped");

      // RULE_11 match needs enable
      chk_match_gate: assert property ( // RULE_11
        !ch_cmp_en[gi] |=> !ch_match[gi])
        else $error("match with compare disabled");

      // RULE_11 equal count matches
      chk_match_fires: assert property ( // RULE_11
        ch_cmp_en[gi] && cnt_step && (cnt_count == ch_value[gi]) |=> ch_match[gi])
        else $error("equal count did not match");
    end
  endgenerate

  // Interrupt trails the match by two edges: flag first, then request
  cov_wrap: cover property (cnt_wrap ##1 state_reg.ovf_flag);
  cov_match: cover property (|ch_match ##2 irq);
  cov_reload: cover property (reload_select && |wr_high);
  cov_clear: cover property (state_reg.ovf_flag && ctrl_wr && !sfr_wdata[7]);
  cov_capture: cover property (|capture_event ##1 |state_reg.mod_flag);
endmodule // cca_array
`default_nettype wire

// [common/cca_pkg.sv]
`default_nettype none
package cca_pkg;
  localparam int NUM_CH = 6;
  localparam logic [7:0] CTRL_ADDR = 8'hD8;
  // Channel 0 sits in the rightmost byte
  localparam logic [NUM_CH-1:0][7:0] LOW_ADDR = {8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
  localparam logic [NUM_CH-1:0][7:0] HIGH_ADDR = {8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  typedef struct packed {
    logic [15:0] count;
    logic step;
    logic wrap;
  } cca_cnt_state_t;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] reload;
    logic cmp_en;
    logic match;
  } cca_ch_state_t;

  typedef struct packed {
    logic ovf_flag;
    logic run;
    logic [NUM_CH-1:0] mod_flag;
    logic [7:0] rdata;
    logic rd_hit;
    logic irq;
  } cca_top_state_t;

  localparam cca_cnt_state_t CNT_RESET = cca_cnt_state_t'(18'h00000);
  localparam cca_ch_state_t CH_RESET = cca_ch_state_t'(34'h000000000);
  localparam cca_top_state_t TOP_RESET = cca_top_state_t'(18'h00000);
endpackage
`default_nettype wire

// [common/cca_chan_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface cca_chan_if;
  logic wr_low;
  logic wr_high;
  logic reload_sel;
  logic [7:0] wdata;
  logic [15:0] count;
  logic step;
  logic [15:0] value;
  logic [15:0] reload;
  logic cmp_en;
  logic match;
  modport ctl (output wr_low, output wr_high, output reload_sel, output wdata, output count, output step,
    input value, input reload, input cmp_en, input match);
  modport chan (input wr_low, input wr_high, input reload_sel, input wdata, input count, input step,
    output value, output reload, output cmp_en, output match);
endinterface
`default_nettype wire

// [rtl/cca_counter.sv]
`timescale 1ns/10ps
`default_nettype none
module cca_counter (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  output logic [15:0] count,
  output logic step,
  output logic wrap
);
  cca_pkg::cca_cnt_state_t state_reg;
  cca_pkg::cca_cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // RULE_03 run gates counting
    state_next.step = run;
    // RULE_01 wrap pulse
    state_next.wrap = run && (state_reg.count == cca_pkg::COUNT_MAX);
    if (run) begin
      state_next.count = state_reg.count + cca_pkg::COUNT_STEP;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cca_pkg::CNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;
  assign step = state_reg.step;
  assign wrap = state_reg.wrap;

  // RULE_03 stopped counter holds
  chk_run_holds: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_03
    !run |=> $stable(count)) else $error("counter moved while stopped");
  // RULE_01 wrap lands on zero
  chk_wrap_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_01
    wrap |-> (count == 16'h0000) && ($past(count) == cca_pkg::COUNT_MAX))
    else $error("wrap pulse without max to zero");
endmodule // cca_counter
`default_nettype wire

// [rtl/cca_channel.sv]
`timescale 1ns/10ps
`default_nettype none
module cca_channel (
  input wire logic core_clk,
  input wire logic rst_b,
  cca_chan_if.chan bus
);
  cca_pkg::cca_ch_state_t state_reg;
  cca_pkg::cca_ch_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // RULE_11 compare against counter
    state_next.match = state_reg.cmp_en && bus.step && (bus.count == state_reg.value);
    if (bus.wr_low) begin
      // RULE_08 reload byte routing
      if (bus.reload_sel) begin
        state_next.reload[7:0] = bus.wdata;
      end else begin
        state_next.value[7:0] = bus.wdata;
      end
      // RULE_09 low write disables
      state_next.cmp_en = 1'b0;
    end
    if (bus.wr_high) begin
      // RULE_07 high byte store
      if (bus.reload_sel) begin
        state_next.reload[15:8] = bus.wdata;
      end else begin
        state_next.value[15:8] = bus.wdata;
      end
      // RULE_10 high write enables
      state_next.cmp_en = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cca_pkg::CH_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.value = state_reg.value;
  assign bus.reload = state_reg.reload;
  assign bus.cmp_en = state_reg.cmp_en;
  assign bus.match = state_reg.match;

  // RULE_09 low write disables
  chk_low_clears: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_09
    bus.wr_low && !bus.wr_high |=> !bus.cmp_en) else $error("low write left compare enabled");
  // RULE_10 high write enables
  chk_high_sets: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_10
    bus.wr_high |=> bus.cmp_en) else $error("high write left compare disabled");
  // RULE_08 reload byte routing
  chk_reload_route: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_08
    bus.wr_high && bus.reload_sel |=> (bus.reload[15:8] == $past(bus.wdata)) && $stable(bus.value))
    else $error("reload write misrouted");
  // RULE_11 match needs equality
  chk_match_equal: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_11
    bus.match |-> $past(bus.cmp_en) && ($past(bus.count) == $past(bus.value)))
    else $error("match without equal count");
endmodule // cca_channel
`default_nettype wire

// [bench/cca_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cca_cpu_model (
  input wire logic core_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // One-cycle strobe; released lines flip so stale data never looks valid
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask
  task automatic wr16(input logic [7:0] lo_a, input logic [7:0] hi_a, input logic [15:0] v);
    access(lo_a, v[7:0], 1'b1);
    access(hi_a, v[15:8], 1'b1);
  endtask
endmodule // cca_cpu_model
`default_nettype wire

// [bench/cca_array_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module cca_array_tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, sfr_rd_hit, irq, reload_select, ovf_int_en, pend;
  logic [5:0] match_int_en, capture_event, compare_enable, match_pulse;
  logic [15:0] count_value, c;
  logic [15:0] vals [2][6];
  logic [31:0] seed = 32'hF330930C;
  logic [8:0] q [$];
  int n_errors = 0;
  int tests_run = 0;
  int i, s, k;
  always #20 core_clk = ~core_clk;
  cca_cpu_model m (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
  cca_array dut_u (.core_clk(core_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .reload_select(reload_select), .ovf_int_en(ovf_int_en), .match_int_en(match_int_en),
    .capture_event(capture_event), .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit), .irq(irq),
    .count_value(count_value), .compare_enable(compare_enable), .match_pulse(match_pulse));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] r;
    r = x ^ (x << 13);
    r = r ^ (r >> 17);
    xorshift = r ^ (r << 5);
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Expected {hit, data} is queued when the read is issued
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    q.push_back(e);
    m.access(a, 8'h00, 1'b0);
  endtask
  always @(posedge core_clk) begin
    if (pend) chk("read", 16'(q.pop_front()), 16'({sfr_rd_hit, sfr_rdata}));
    pend = sfr_rd;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  initial begin
    #(40 * 90000);
    n_errors++;
    end_sim();
  end
  initial begin
    pend = 1'b0;
    reload_select = 1'b0;
    ovf_int_en = 1'b0;
    match_int_en = 6'h00;
    capture_event = 6'h00;
    cyc(3);
    rst_b = 1'b1;
    rd(cca_pkg::CTRL_ADDR, 9'h100);
    for (i = 0; i < 6; i++) begin
      rd(cca_pkg::LOW_ADDR[i], 9'h100);
      rd(cca_pkg::HIGH_ADDR[i], 9'h100);
    end
    m.access(8'hCC, 8'h5A, 1'b1);
    rd(8'hCC, 9'h000);
    for (s = 0; s < 2; s++) begin
      reload_select = s[0];
      for (i = 0; i < 6; i++) begin
        seed = xorshift(seed);
        vals[s][i] = seed[15:0];
        m.access(cca_pkg::LOW_ADDR[i], seed[7:0], 1'b1);
        chk("cmp_en", 16'h0000, 16'(compare_enable[i]));
        m.access(cca_pkg::HIGH_ADDR[i], seed[15:8], 1'b1);
        chk("cmp_en", 16'h0001, 16'(compare_enable[i]));
      end
    end
    for (s = 0; s < 2; s++) begin
      reload_select = s[0];
      for (i = 0; i < 6; i++) begin
        rd(cca_pkg::LOW_ADDR[i], {1'b1, vals[s][i][7:0]});
        rd(cca_pkg::HIGH_ADDR[i], {1'b1, vals[s][i][15:8]});
        m.access(cca_pkg::LOW_ADDR[i], 8'h00, 1'b1);
      end
    end
    reload_select = 1'b0;
    chk("cmp_off", 16'h0000, 16'(compare_enable));
    m.access(cca_pkg::CTRL_ADDR, 8'h3F, 1'b1);
    rd(cca_pkg::CTRL_ADDR, 9'h13F);
    match_int_en = 6'h04;
    cyc(3);
    chk("irq", 16'h0001, 16'(irq));
    chk("count", 16'h0000, count_value);
    match_int_en = 6'h00;
    m.access(cca_pkg::CTRL_ADDR, 8'h00, 1'b1);
    capture_event = 6'h08;
    cyc(1);
    capture_event = 6'h00;
    rd(cca_pkg::CTRL_ADDR, 9'h108);
    chk("irq", 16'h0000, 16'(irq));
    m.wr16(cca_pkg::LOW_ADDR[0], cca_pkg::HIGH_ADDR[0], 16'h0005);
    match_int_en = 6'h01;
    m.access(cca_pkg::CTRL_ADDR, 8'h40, 1'b1);
    for (k = 0; k < 20 && match_pulse[0] !== 1'b1; k++) cyc(1);
    chk("match", 16'h0001, 16'(match_pulse));
    cyc(3);
    chk("irq", 16'h0001, 16'(irq));
    rd(cca_pkg::CTRL_ADDR, 9'h141);
    m.access(cca_pkg::LOW_ADDR[0], 8'h05, 1'b1);
    match_int_en = 6'h00;
    ovf_int_en = 1'b1;
    for (k = 0; k < 70000 && count_value !== 16'h0002; k++) cyc(1);
    rd(cca_pkg::CTRL_ADDR, 9'h1C1);
    chk("irq", 16'h0001, 16'(irq));
    m.access(cca_pkg::CTRL_ADDR, 8'h00, 1'b1);
    cyc(2);
    c = count_value;
    cyc(5);
    chk("count", c, count_value);
    rd(cca_pkg::CTRL_ADDR, 9'h100);
    chk("irq", 16'h0000, 16'(irq));
    cyc(2);
    end_sim();
  end
endmodule // cca_array_tb_top
`default_nettype wire
